/* shared/hsw_consts.vh */
`ifndef HSW_CONSTS_VH
`define HSW_CONSTS_VH

// ****************************************************************
// Clock and time base
// ****************************************************************
// Core clock rate in MHz and the period of the internal time tick in us.
`define HSW_CLK_MHZ          125
`define HSW_TICK_US          1
// Cycles per tick, derived from the rate and the tick period.
`define HSW_TICK_CYCLES      (`HSW_TICK_US * `HSW_CLK_MHZ)
// Ticks in one millisecond.
`define HSW_TICKS_PER_MS     (1000 / `HSW_TICK_US)

// ****************************************************************
// Durations, each as printed, then converted to ticks
// ****************************************************************
`define HSW_THERMAL_US       12
`define HSW_THERMAL_TICKS    (`HSW_THERMAL_US / `HSW_TICK_US)
`define HSW_RANGE_MS         1
`define HSW_RANGE_TICKS      (`HSW_RANGE_MS * `HSW_TICKS_PER_MS)
`define HSW_OC_MS            3
`define HSW_OC_TICKS         (`HSW_OC_MS * `HSW_TICKS_PER_MS)
`define HSW_DIS_MS           1
`define HSW_DIS_TICKS        (`HSW_DIS_MS * `HSW_TICKS_PER_MS)
`define HSW_PG_MS            20
`define HSW_PG_TICKS         (`HSW_PG_MS * `HSW_TICKS_PER_MS)

// ****************************************************************
// Start-up delay setting, charge limit and rise time, overcurrent limit
// ****************************************************************
`define HSW_TIMER_OFS_MS     12'h014
`define HSW_TIMER_MIN_MS     12'h064
`define HSW_TIMER_MAX_MS     12'h3e8
`define HSW_TIMER_DEF_MS     12'h0c8
`define HSW_CHG_MIN_MA       12'h032
`define HSW_CHG_MAX_MA       12'h1f4
`define HSW_CHG_DEF_MA       12'h064
`define HSW_RISE_MIN_MS      12'h001
`define HSW_RISE_MAX_MS      12'h00a
`define HSW_RISE_DEF_MS      12'h001
`define HSW_OCL_MIN_MA       12'h15e
`define HSW_OCL_MAX_MA       12'h8ca
`define HSW_OCL_DEF_MA       12'h3e8

// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define HSW_REG_CTRL         8'h00
`define HSW_REG_STATUS       8'h04
`define HSW_REG_INT_STAT     8'h08
`define HSW_REG_INT_MASK     8'h0c
`define HSW_REG_RETRY        8'h10
`define HSW_REG_TIMER        8'h14
`define HSW_REG_LIMITS       8'h18
`define HSW_REG_CURRENT      8'h1c
`define HSW_CTRL_SW_DIS      0
`define HSW_EV_PG_RISE       0
`define HSW_EV_PG_FALL       1
`define HSW_EV_RANGE         2
`define HSW_EV_THERMAL       3
`define HSW_EV_OC            4
`define HSW_EV_DISABLE       5
`define HSW_EV_W             6

`endif

/* hdl/hsw_sequencer.v */
// Our own choices: strobed register access and the address map.
`include "hsw_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module hsw_sequencer #(
  parameter [15:0] TICK_CYCLES    = `HSW_TICK_CYCLES,
  parameter [10:0] TICKS_PER_MS   = `HSW_TICKS_PER_MS,
  parameter [15:0] RANGE_TICKS    = `HSW_RANGE_TICKS,
  parameter [15:0] OC_TICKS       = `HSW_OC_TICKS,
  parameter [15:0] DIS_TICKS      = `HSW_DIS_TICKS,
  parameter [15:0] PG_TICKS       = `HSW_PG_TICKS,
  parameter [15:0] THERMAL_TICKS  = `HSW_THERMAL_TICKS
) (
  // Clock, reset and clock enable.
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        clk_en,
  // Register port.
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg         irq,
  // Analog comparator and sense inputs.
  input  wire        supply_lockout_ok,
  input  wire        undervoltage_detect,
  input  wire        overvoltage_detect,
  input  wire        thermal_detect,
  input  wire        overcurrent_detect,
  input  wire        gate_full_enh,
  input  wire        disable_in,
  // External setting component sense.
  input  wire        timer_res_present,
  input  wire [9:0]  timer_res_kohm,
  input  wire        charge_res_present,
  input  wire [9:0]  charge_sense_ma,
  input  wire [3:0]  charge_rise_ms,
  input  wire        oc_res_present,
  input  wire [11:0] oc_sense_ma,
  // Power stage and load.
  output reg         pass_on,
  output reg  [11:0] current_limit_ma,
  output reg         limit_is_overcurrent,
  output reg         power_good_out,
  output reg         power_good_out_n
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [5:0] ST_OFF    = 6'h01;
  localparam [5:0] ST_DELAY  = 6'h02;
  localparam [5:0] ST_CHARGE = 6'h04;
  localparam [5:0] ST_SETTLE = 6'h08;
  localparam [5:0] ST_NORMAL = 6'h10;
  localparam [5:0] ST_OCWAIT = 6'h20;
  localparam       PIN_W     = 46;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Limits a sensed setting to its legal span.
  function [11:0] hsw_clamp;
    input [11:0] v;
    input [11:0] lo;
    input [11:0] hi;
    begin
      if (v < lo) begin
        hsw_clamp = lo;
      end else if (v > hi) begin
        hsw_clamp = hi;
      end else begin
        hsw_clamp = v;
      end
    end
  endfunction

  // Chooses the sensed setting when a component is present, else the default.
  function [11:0] hsw_pick;
    input        present;
    input [11:0] v;
    input [11:0] lo;
    input [11:0] hi;
    input [11:0] dflt;
    begin
      hsw_pick = present ? hsw_clamp(v, lo, hi) : dflt;
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire [PIN_W-1:0] pin_raw;
  reg  [PIN_W-1:0] pin_s1;
  reg  [PIN_W-1:0] pin_s2;
  reg  [PIN_W-1:0] pin_s3;
  reg  [PIN_W-1:0] pin_q;
  integer          i;

  assign pin_raw = {oc_sense_ma, charge_rise_ms, charge_sense_ma, timer_res_kohm,
                    oc_res_present, charge_res_present, timer_res_present,
                    disable_in, gate_full_enh, overcurrent_detect, thermal_detect,
                    overvoltage_detect, undervoltage_detect, supply_lockout_ok};

  // Three stages; a bit changes only once stages two and three agree. Sense
  // buses are quasi-static, so a bit-wise update is good enough for them.
  always @(posedge mclk) begin
    if (sys_rst) begin
      pin_s1 <= {PIN_W{1'b0}};
      pin_s2 <= {PIN_W{1'b0}};
      pin_s3 <= {PIN_W{1'b0}};
      pin_q  <= {PIN_W{1'b0}};
    end else if (clk_en) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (i = 0; i < PIN_W; i = i + 1) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_q[i] <= pin_s3[i];
        end
      end
    end
  end

  wire        lockout_ok = pin_q[0];
  wire        range_bad  = pin_q[1] | pin_q[2];
  wire        hot        = pin_q[3];
  wire        oc_now     = pin_q[4];
  wire        gate_full  = pin_q[5];
  wire        dis_now    = pin_q[6];

  // ****************************************************************
  // Settings
  // ****************************************************************
  wire [11:0] timer_sensed = {1'b0, pin_q[19:10], 1'b0} + `HSW_TIMER_OFS_MS + 12'h002;
  wire [11:0] timer_ms     = hsw_pick(pin_q[7], timer_sensed, `HSW_TIMER_MIN_MS,
                                      `HSW_TIMER_MAX_MS, `HSW_TIMER_DEF_MS);
  wire [11:0] chg_ma       = hsw_pick(pin_q[8], {2'b00, pin_q[29:20]}, `HSW_CHG_MIN_MA,
                                      `HSW_CHG_MAX_MA, `HSW_CHG_DEF_MA);
  wire [11:0] rise_ms      = hsw_pick(pin_q[8] && (pin_q[33:30] != 4'h0),
                                      {8'h00, pin_q[33:30]}, `HSW_RISE_MIN_MS,
                                      `HSW_RISE_MAX_MS, `HSW_RISE_DEF_MS);
  wire [11:0] ocl_ma       = hsw_pick(pin_q[9], pin_q[45:34], `HSW_OCL_MIN_MA,
                                      `HSW_OCL_MAX_MA, `HSW_OCL_DEF_MA);
  wire [23:0] timer_ticks  = {12'h000, timer_ms} * {13'h0000, TICKS_PER_MS};
  wire [23:0] rise_ticks   = {12'h000, rise_ms} * {13'h0000, TICKS_PER_MS};

  // ****************************************************************
  // Time tick and persistence filters
  // ****************************************************************
  reg  [15:0] tick_cnt;
  reg         tick;
  reg  [15:0] therm_cnt;
  reg  [15:0] range_cnt;
  reg  [15:0] dis_cnt;
  reg         dis_q;
  wire        therm_q = (therm_cnt >= THERMAL_TICKS);
  wire        range_q = (range_cnt >= RANGE_TICKS);

  // Every filter counts whole ticks and restarts when its condition drops, so
  // the qualified length is accurate to one tick.
  always @(posedge mclk) begin
    if (sys_rst) begin
      tick_cnt  <= 16'h0000;
      tick      <= 1'b0;
      therm_cnt <= 16'h0000;
      range_cnt <= 16'h0000;
      dis_cnt   <= 16'h0000;
      dis_q     <= 1'b0;
    end else if (clk_en) begin
      tick     <= (tick_cnt == TICK_CYCLES - 16'h0001);
      tick_cnt <= (tick_cnt == TICK_CYCLES - 16'h0001) ? 16'h0000 : tick_cnt + 16'h0001;
      if (!hot) begin
        therm_cnt <= 16'h0000;
      end else if (tick && !therm_q) begin
        therm_cnt <= therm_cnt + 16'h0001;
      end
      if (!range_bad) begin
        range_cnt <= 16'h0000;
      end else if (tick && !range_q) begin
        range_cnt <= range_cnt + 16'h0001;
      end
      // The disable filter works on both edges, so a short release is ignored too.
      if (dis_now == dis_q) begin
        dis_cnt <= 16'h0000;
      end else if (tick) begin
        if (dis_cnt >= DIS_TICKS - 16'h0001) begin
          dis_q   <= dis_now;
          dis_cnt <= 16'h0000;
        end else begin
          dis_cnt <= dis_cnt + 16'h0001;
        end
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  reg  [5:0]  state;
  reg  [5:0]  next_state;
  reg  [23:0] seq_cnt;
  reg  [7:0]  retry_cnt;
  reg         sw_disable;
  reg         restart;
  reg         retry_inc;
  reg         retry_clr;
  reg  [`HSW_EV_W-1:0] next_ev;
  wire        dis_active = dis_q | sw_disable;
  wire        running    = (state != ST_OFF);

  // Disable and lockout take priority over faults; thermal beats range,
  // range beats overcurrent.
  always @* begin
    next_state = state;
    restart    = 1'b0;
    retry_inc  = 1'b0;
    retry_clr  = 1'b0;
    next_ev    = {`HSW_EV_W{1'b0}};
    if (!lockout_ok) begin
      next_state = ST_OFF;
    end else if (dis_active) begin
      next_state = ST_OFF;
      retry_clr  = 1'b1;
      next_ev[`HSW_EV_DISABLE] = running;
    end else begin
      case (state)
        ST_OFF: begin
          if (!dis_now) begin
            next_state = ST_DELAY;
          end
        end
        ST_DELAY, ST_CHARGE, ST_SETTLE, ST_NORMAL, ST_OCWAIT: begin
          if (therm_q) begin
            next_state = ST_DELAY;
            restart    = 1'b1;
            retry_inc  = 1'b1;
            next_ev[`HSW_EV_THERMAL] = 1'b1;
          end else if (range_q) begin
            next_state = ST_DELAY;
            restart    = 1'b1;
            retry_inc  = (state != ST_DELAY);
            next_ev[`HSW_EV_RANGE] = 1'b1;
          end else begin
            case (state)
              ST_DELAY: begin
                if (seq_cnt >= timer_ticks) begin
                  next_state = ST_CHARGE;
                end
              end
              ST_CHARGE: begin
                if (gate_full) begin
                  next_state = ST_SETTLE;
                end
              end
              ST_SETTLE: begin
                if (seq_cnt >= {8'h00, PG_TICKS}) begin
                  next_state = ST_NORMAL;
                  retry_clr  = 1'b1;
                end
              end
              ST_NORMAL: begin
                if (oc_now) begin
                  next_state = ST_OCWAIT;
                end
              end
              ST_OCWAIT: begin
                if (!oc_now) begin
                  next_state = ST_NORMAL;
                end else if (seq_cnt >= {8'h00, OC_TICKS}) begin
                  next_state = ST_DELAY;
                  restart    = 1'b1;
                  retry_inc  = 1'b1;
                  next_ev[`HSW_EV_OC] = 1'b1;
                end
              end
              default: begin
                next_state = ST_OFF;
              end
            endcase
          end
        end
        default: begin
          next_state = ST_OFF;
        end
      endcase
    end
  end

  // State, shared stage counter and retry counter.
  always @(posedge mclk) begin
    if (sys_rst) begin
      state     <= ST_OFF;
      seq_cnt   <= 24'h000000;
      retry_cnt <= 8'h00;
    end else if (clk_en) begin
      state <= next_state;
      if ((next_state != state) || restart) begin
        seq_cnt <= 24'h000000;
      end else if (tick) begin
        seq_cnt <= seq_cnt + 24'h000001;
      end
      if (retry_clr) begin
        retry_cnt <= 8'h00;
      end else if (retry_inc && (retry_cnt != 8'hff)) begin
        retry_cnt <= retry_cnt + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Charge ramp and outputs
  // ****************************************************************
  reg  [11:0] ramp_ma;
  reg  [23:0] ramp_acc;
  wire [23:0] acc_sum = ramp_acc + {12'h000, chg_ma};
  wire        on_next = (next_state == ST_CHARGE) || (next_state == ST_SETTLE) ||
                        (next_state == ST_NORMAL) || (next_state == ST_OCWAIT);
  wire        pg_next = (next_state == ST_NORMAL) || (next_state == ST_OCWAIT);

  // Error-accumulating ramp: one mA step each time the sum passes the rise
  // length, at most one per tick, so the limit reaches its target after rise_ticks or chg_ma ticks, whichever is later.
  always @(posedge mclk) begin
    if (sys_rst) begin
      ramp_ma  <= 12'h000;
      ramp_acc <= 24'h000000;
    end else if (clk_en) begin
      if (next_state != ST_CHARGE) begin
        ramp_ma  <= 12'h000;
        ramp_acc <= 24'h000000;
      end else if (tick && (ramp_ma < chg_ma)) begin
        if (acc_sum >= rise_ticks) begin
          ramp_acc <= acc_sum - rise_ticks;
          ramp_ma  <= ramp_ma + 12'h001;
        end else begin
          ramp_acc <= acc_sum;
        end
      end
    end
  end

  // Outputs follow the next state so they change in the same cycle as it.
  always @(posedge mclk) begin
    if (sys_rst) begin
      pass_on              <= 1'b0;
      current_limit_ma     <= 12'h000;
      limit_is_overcurrent <= 1'b0;
      power_good_out       <= 1'b0;
      power_good_out_n     <= 1'b1;
    end else if (clk_en) begin
      pass_on <= on_next;
      if (next_state == ST_CHARGE) begin
        current_limit_ma     <= ramp_ma;
        limit_is_overcurrent <= 1'b0;
      end else if (on_next) begin
        current_limit_ma     <= ocl_ma;
        limit_is_overcurrent <= 1'b1;
      end else begin
        current_limit_ma     <= 12'h000;
        limit_is_overcurrent <= 1'b0;
      end
      power_good_out   <= pg_next;
      power_good_out_n <= ~pg_next;
    end
  end

  // ****************************************************************
  // Register port and interrupt
  // ****************************************************************
  reg  [`HSW_EV_W-1:0] int_stat;
  reg  [`HSW_EV_W-1:0] int_mask;
  reg  [31:0]          rd_mux;
  wire [`HSW_EV_W-1:0] ev_all;

  assign ev_all = next_ev | {4'h0, power_good_out & ~pg_next, ~power_good_out & pg_next};

  // Read multiplexer; unmapped offsets read as zero.
  always @* begin
    case (reg_addr)
      `HSW_REG_CTRL:     rd_mux = {31'h0, sw_disable};
      `HSW_REG_STATUS:   rd_mux = {19'h0, limit_is_overcurrent, oc_now, therm_q, range_q,
                                   dis_q, pass_on, power_good_out, state};
      `HSW_REG_INT_STAT: rd_mux = {26'h0, int_stat};
      `HSW_REG_INT_MASK: rd_mux = {26'h0, int_mask};
      `HSW_REG_RETRY:    rd_mux = {24'h0, retry_cnt};
      `HSW_REG_TIMER:    rd_mux = {20'h0, timer_ms};
      `HSW_REG_LIMITS:   rd_mux = {4'h0, ocl_ma, 4'h0, chg_ma};
      `HSW_REG_CURRENT:  rd_mux = {20'h0, current_limit_ma};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // Status bits are write-one-to-clear; a new event in the same cycle wins.
  always @(posedge mclk) begin
    if (sys_rst) begin
      sw_disable <= 1'b0;
      int_stat   <= {`HSW_EV_W{1'b0}};
      int_mask   <= {`HSW_EV_W{1'b0}};
      reg_rdata  <= 32'h00000000;
      irq        <= 1'b0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      if (reg_wr && (reg_addr == `HSW_REG_CTRL)) begin
        sw_disable <= reg_wdata[`HSW_CTRL_SW_DIS];
      end
      if (reg_wr && (reg_addr == `HSW_REG_INT_MASK)) begin
        int_mask <= reg_wdata[`HSW_EV_W-1:0];
      end
      if (reg_wr && (reg_addr == `HSW_REG_INT_STAT)) begin
        int_stat <= (int_stat & ~reg_wdata[`HSW_EV_W-1:0]) | ev_all;
      end else begin
        int_stat <= int_stat | ev_all;
      end
      irq <= |((int_stat | ev_all) & int_mask);
    end
  end

endmodule

`default_nettype wire

/* test/hsw_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************
// Sequencer port checker
// ********************
module hsw_checker #(
  parameter int TICK_CYCLES   = 125,
  parameter int RANGE_TICKS   = 1000,
  parameter int OC_TICKS      = 3000,
  parameter int DIS_TICKS     = 1000,
  parameter int PG_TICKS      = 20000,
  parameter int THERMAL_TICKS = 12
) (
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        sys_rst,
  // Register port.
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Sense inputs.
  input wire logic        undervoltage_detect,
  input wire logic        overvoltage_detect,
  input wire logic        thermal_detect,
  input wire logic        overcurrent_detect,
  input wire logic        disable_in,
  input wire logic        oc_res_present,
  // Power stage and load.
  input wire logic        pass_on,
  input wire logic [11:0] current_limit_ma,
  input wire logic        limit_is_overcurrent,
  input wire logic        power_good_out,
  input wire logic        power_good_out_n
);
  // Slack covers one tick of phase, the input synchroniser and the output flop.
  localparam int LTH = (THERMAL_TICKS + 2) * TICK_CYCLES + 8;
  localparam int LRG = (RANGE_TICKS + 2) * TICK_CYCLES + 8;
  localparam int LOC = (OC_TICKS + 2) * TICK_CYCLES + 8;
  localparam int LDS = (DIS_TICKS + 2) * TICK_CYCLES + 8;
  localparam int PLO = (PG_TICKS - 1) * TICK_CYCLES;
  localparam int PHI = (PG_TICKS + 1) * TICK_CYCLES + 8;
  logic [15:0] cth, crg, coc, cds, col;
  // Run lengths in cycles; any drop of the condition restarts its count.
  always @(posedge mclk) begin
    if (sys_rst) begin
      {cth, crg, coc, cds, col} <= 80'h0;
    end else begin
      cth <= thermal_detect ? cth + 16'h0001 : 16'h0000;
      crg <= (undervoltage_detect || overvoltage_detect) ? crg + 16'h0001 : 16'h0000;
      coc <= overcurrent_detect ? coc + 16'h0001 : 16'h0000;
      cds <= disable_in ? cds + 16'h0001 : 16'h0000;
      col <= limit_is_overcurrent ? col + 16'h0001 : 16'h0000;
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_PG_POLARITY: assert property (power_good_out_n == !power_good_out)
    else $error("power good outputs disagree");
  AST_PG_ON: assert property (power_good_out |-> pass_on && limit_is_overcurrent)
    else $error("power good without enhanced pass stage");
  AST_PG_DELAY: assert property ($rose(power_good_out) |-> col >= PLO && col <= PHI)
    else $error("power good delay off");
  AST_RAMP_ZERO: assert property ($rose(pass_on) |-> current_limit_ma < 12'h032)
    else $error("limit did not start near zero");
  AST_RAMP_UP: assert property (pass_on && $past(pass_on) && !limit_is_overcurrent
    |-> current_limit_ma >= $past(current_limit_ma)) else $error("charge limit fell");
  AST_OC_LIMIT: assert property (limit_is_overcurrent && !oc_res_present
    |-> pass_on && current_limit_ma == 12'h3e8) else $error("overcurrent limit wrong");
  AST_THERMAL: assert property (cth >= LTH |-> !power_good_out)
    else $error("thermal fault kept power good");
  AST_RANGE: assert property (crg >= LRG |-> !power_good_out && !pass_on)
    else $error("range fault kept pass stage on");
  AST_OVERCURRENT: assert property (coc >= LOC |-> !power_good_out && !pass_on)
    else $error("overcurrent kept pass stage on");
  AST_DISABLE: assert property (cds >= LDS |-> !power_good_out && !pass_on)
    else $error("disable ignored");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind hsw_sequencer hsw_checker #(.TICK_CYCLES(TICK_CYCLES), .RANGE_TICKS(RANGE_TICKS),
  .OC_TICKS(OC_TICKS), .DIS_TICKS(DIS_TICKS), .PG_TICKS(PG_TICKS),
  .THERMAL_TICKS(THERMAL_TICKS)) i_chk (.mclk(mclk), .sys_rst(sys_rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .undervoltage_detect(undervoltage_detect),
  .overvoltage_detect(overvoltage_detect), .thermal_detect(thermal_detect),
  .overcurrent_detect(overcurrent_detect), .disable_in(disable_in),
  .oc_res_present(oc_res_present), .pass_on(pass_on), .current_limit_ma(current_limit_ma),
  .limit_is_overcurrent(limit_is_overcurrent), .power_good_out(power_good_out),
  .power_good_out_n(power_good_out_n));
`default_nettype wire

/* test/hsw_load_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************
// Load capacitor and power module
// ********************
module hsw_load_model #(
  parameter int FULL_CYC = 200
) (
  // Clock.
  input  wire logic mclk,
  // Power stage and power good.
  input  wire logic pass_on,
  input  wire logic power_good_out,
  input  wire logic power_good_out_n,
  // Bench command and sense outputs.
  input  wire logic oc_cmd,
  output var  logic gate_full_enh,
  output var  logic overcurrent_detect
);
  logic [15:0] chg;
  // The capacitor charges only while the pass stage conducts; switching off empties it.
  always @(posedge mclk) begin
    chg <= pass_on ? chg + 16'h0001 : 16'h0000;
    gate_full_enh <= pass_on && chg >= FULL_CYC;
  end
  // Excess current needs the load enabled by both polarities, so a wrong one hides it.
  always @* begin
    overcurrent_detect = oc_cmd && pass_on && power_good_out && !power_good_out_n;
  end
endmodule
`default_nettype wire

/* test/tb_hot_swap_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************
// Sequencer testbench
// ********************
module tb_hot_swap_sequencer;
  localparam int FULL = 240;
  logic        mclk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, r = 32'h96ff;
  logic        lock_ok = 1'b1, uv = 1'b0, ov = 1'b0, therm = 1'b0, dis = 1'b1, oc_cmd = 1'b0;
  logic        t_pres = 1'b0, c_pres = 1'b0, o_pres = 1'b0, gfull, ocd, irq;
  logic [9:0]  kohm = 10'h000, c_ma = 10'h000;
  logic [3:0]  c_rise = 4'h0;
  logic [11:0] o_ma = 12'h000, lim;
  logic        pass, lim_oc, pg, pg_n;
  int          n_errors = 0, cmp_count = 0, cycles = 0, n;
  // Short counts keep each start-up near two thousand cycles.
  hsw_sequencer #(.TICK_CYCLES(16'h0002), .TICKS_PER_MS(11'h004), .RANGE_TICKS(16'h0004),
    .OC_TICKS(16'h0006), .DIS_TICKS(16'h0004), .PG_TICKS(16'h0008),
    .THERMAL_TICKS(16'h0002)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .supply_lockout_ok(lock_ok),
    .undervoltage_detect(uv), .overvoltage_detect(ov), .thermal_detect(therm),
    .overcurrent_detect(ocd), .gate_full_enh(gfull), .disable_in(dis),
    .timer_res_present(t_pres), .timer_res_kohm(kohm), .charge_res_present(c_pres),
    .charge_sense_ma(c_ma), .charge_rise_ms(c_rise), .oc_res_present(o_pres),
    .oc_sense_ma(o_ma), .pass_on(pass), .current_limit_ma(lim),
    .limit_is_overcurrent(lim_oc), .power_good_out(pg), .power_good_out_n(pg_n));
  hsw_load_model #(.FULL_CYC(FULL)) i_load (.mclk(mclk), .pass_on(pass),
    .power_good_out(pg), .power_good_out_n(pg_n), .oc_cmd(oc_cmd),
    .gate_full_enh(gfull), .overcurrent_detect(ocd));
  // Free-running clock at 125 MHz.
  always #4 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected delay in ms for a sensed resistance, clamped to the legal span.
  function automatic logic [31:0] dly_ms(input int k);
    int m;
    m = 22 + 2 * k;
    return (m < 100) ? 32'h0000_0064 : (m > 1000) ? 32'h0000_03e8 : m;
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask
  // Read data are taken at the edge that closes the cycle after the strobe.
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    cyc(1);
    cmp(nm, e, reg_rdata);
  endtask
  // Waits, bounded, for the pass stage or power good to reach a level.
  task automatic wt(input bit s, input logic v, output int k);
    k = 0;
    while (((s ? pg : pass) !== v) && k < 20000) begin
      cyc(1);
      k++;
    end
  endtask
  // One start-up at the default 200 ms delay: ramp, hand-over, power good.
  task automatic up;
    wt(0, 1'b1, n);
    cmp("delay", 32'h1, n >= 1500 && n <= 1640);
    cyc(FULL - 20);
    cmp("charge limit", 32'h64, lim);
    wt(1, 1'b1, n);
    cmp("pg delay", 32'h1, n >= 25 && n <= 70);
    cmp("oc limit", 32'h3e8, lim);
    cmp("pg_n", 32'h0, pg_n);
    rdc("retry", 8'h10, 32'h0);
  endtask
  // One fault of kind s for len cycles, then the expected power state.
  task automatic pulse(input int s, input int len, input logic on);
    case (s)
      0: therm <= 1'b1;
      1: {uv, ov} <= r[0] ? 2'b10 : 2'b01;
      2: oc_cmd <= 1'b1;
      default: dis <= 1'b1;
    endcase
    cyc(len);
    {therm, uv, ov, oc_cmd, dis} <= 5'h00;
    cyc(30);
    cmp("pg", on, pg);
    cmp("pg_n", !on, pg_n);
    cmp("pass", on, pass);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cuts a hang short well past the expected run length.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      test_done;
    end
  end
  // Main sequence: configuration while disabled, start-up, faults, software disable.
  initial begin
    int k;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(1);
    cmp("pg", 32'h0, pg);
    cmp("pg_n", 32'h1, pg_n);
    cmp("irq", 32'h0, irq);
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      k = (i == 0) ? 0 : (i == 1) ? 39 : (i == 2) ? 600 : 39 + r % 451;
      t_pres <= 1'b1;
      c_pres <= r[26];
      o_pres <= r[27];
      kohm <= k[9:0];
      {c_ma, c_rise, o_ma} <= r[25:0];
      cyc(12);
      rdc("delay ms", 8'h14, dly_ms(k));
    end
    t_pres <= 1'b0;
    c_pres <= 1'b0;
    o_pres <= 1'b0;
    cyc(12);
    rdc("delay ms", 8'h14, 32'hc8);
    rdc("limits", 8'h18, 32'h03e8_0064);
    rdc("unmapped", 8'h40, 32'h0);
    wr(8'h04, 32'hffff_ffff);
    rdc("status", 8'h04, 32'h101);
    cmp("pass", 32'h0, pass);
    wr(8'h0c, 32'h02);
    tend("configuration");
    dis <= 1'b0;
    up;
    tend("start-up");
    for (int s = 0; s < 4; s++) begin
      r = lfsr(r);
      pulse(s, (s == 0) ? 1 : 1 + r % 3, 1'b1);
      pulse(s, 20 * (s + 1), 1'b0);
      if (s >= 2) rdc("retry", 8'h10, (s == 2) ? 32'h1 : 32'h0);
      if (s == 0) begin
        cmp("irq", 32'h1, irq);
        wr(8'h08, 32'h02);
        cyc(2);
        cmp("irq", 32'h0, irq);
      end
      up;
      tend("fault");
    end
    wr(8'h00, 32'h1);
    cyc(10);
    cmp("pass", 32'h0, pass);
    cmp("pg", 32'h0, pg);
    wr(8'h00, 32'h0);
    tend("software disable");
    test_done;
  end
endmodule
`default_nettype wire
